// *** logic/rail_monitor_defines.svh ***
`ifndef RAIL_MONITOR_DEFINES_SVH
`define RAIL_MONITOR_DEFINES_SVH
`define RMD_LDO4_OFS 16'h8028
`define RMD_LDO5_OFS 16'h802c
`define RMD_LDO6_OFS 16'h8030
`define RMD_LDO7_OFS 16'h8034
`define RMD_WARN_OFS 16'h8038
`define RMD_FAULT_OFS 16'h803c
`define RMD_ERR_OFS 16'h8040
`define RMD_TRIG_OFS 16'h8044
`define RMD_STAT_OFS 16'h8048
`define RMD_A_CTRL_OFS 16'h804c
`define RMD_A_HI_OFS 16'h8050
`define RMD_A_LO_OFS 16'h8054
`define RMD_A_WID_OFS 16'h8058
`define RMD_B_CTRL_OFS 16'h805c
`define RMD_B_HI_OFS 16'h8060
`define RMD_B_LO_OFS 16'h8064
`define RMD_LDO_LOW_RST 3'h1
`define RMD_LDO_HIGH_RST 2'h1
`define RMD_WARN_RST 28'h5555555
`define RMD_FAULT_RST 28'hfaaaaaa
`define RMD_ERR_LIMIT_RST 3'h7
`define RMD_ERR_PER_LSB 3
`define RMD_ERR_SYS_LSB 0
`define RMD_STAT_PASS_LSB 9
`define RMD_STAT_ALL_PASS 8
`define RMD_STAT_DONE_LSB 1
`define RMD_STAT_ALL_DONE 0
`define RMD_HI_RST 18'h0047e
`define RMD_LO_RST 18'h00352
`define RMD_WID_RST 18'h00898
`define RMD_CTRL_RST 3'h0
`define RMD_CLK_NS 10
`define RMD_TICK_NS 500
`define RMD_TICK_CYC (`RMD_TICK_NS / `RMD_CLK_NS)
`endif

// *** logic/rail_monitor_diag_registers.sv ***
`timescale 1ns/1ns
`include "rail_monitor_defines.svh"

// What this block does
// [RULE1] regulators 4,5: 3-bit code, reset 1
// [RULE2] regulators 6,7: 2-bit code, reset 1
// [RULE3] fourteen warning width fields, reset 01
// [RULE4] fourteen fault widths, external 8%, feedback 6%
// [RULE5] peripheral error limit field, reset 7
// [RULE6] system error limit field, reset 7
// [RULE7] host writes one to start self test
// [RULE8] seven per-check done flags, bits 7..1
// [RULE9] seven per-check pass flags, bits 15..9
// [RULE10] bit 8 overall pass, bit 0 overall done
// [RULE11] input a width check runs when enabled
// [RULE12] input a long pulse fault, maskable
// [RULE13] input a short pulse fault, maskable
// [RULE14] input a long limit, 500 ns units
// [RULE15] input a short limit, 500 ns units
// [RULE16] self test records input a pulse width
// [RULE17] input b masks behave like input a
// [RULE18] input b control bit 0 enables check
// [RULE19] input b long limit, 500 ns units
// [RULE20] new trigger clears done and pass flags
// [RULE21] reserved bits read zero, ignore writes
module rail_monitor_diag_registers #(
	parameter int WIDTH_BITS = 18
) (
	// clock and reset
	input wire logic i_mclk,
	input wire logic i_rst,
	// decoded register access from the serial control port
	input wire rail_monitor_pkg::reg_req_t i_req,
	output logic [31:0] o_rdata,
	output logic o_rvalid,
	// regulator and monitor settings
	output logic [2:0] o_reg4_voltage_code,
	output logic [2:0] o_reg5_voltage_code,
	output logic [1:0] o_reg6_voltage_code,
	output logic [1:0] o_reg7_voltage_code,
	output logic [27:0] o_warning_widths,
	output logic [27:0] o_fault_widths,
	output logic [2:0] o_peripheral_error_limit,
	output logic [2:0] o_system_error_limit,
	// self test
	output logic o_selftest_go,
	input wire logic [6:0] i_check_done,
	input wire logic [6:0] i_check_pass,
	// watchdog input pins and pulse width faults
	input wire logic i_watchdog_input_a,
	input wire logic i_watchdog_input_b,
	output logic [1:0] o_long_fault,
	output logic [1:0] o_short_fault
);
	localparam logic [5:0] TICK_LAST = 6'(`RMD_TICK_CYC - 1);

	rail_monitor_pkg::pulse_ctrl_t ctrl [2], next_ctrl [2];
	logic [WIDTH_BITS-1:0] long_limit [2], next_long_limit [2];
	logic [WIDTH_BITS-1:0] short_limit [2], next_short_limit [2];
	logic [WIDTH_BITS-1:0] selftest_width, next_selftest_width;
	logic [WIDTH_BITS-1:0] width_seen [2];
	logic pulse_end [2];
	logic [2:0] next_reg4, next_reg5;
	logic [1:0] next_reg6, next_reg7;
	logic [27:0] next_warn, next_fault;
	logic [2:0] next_per, next_sys;
	logic trig, next_trig, next_go;
	logic busy, next_busy;
	logic [6:0] done, next_done, pass, next_pass;
	logic [5:0] tick_cnt, next_tick_cnt;
	logic tick, next_tick;
	logic [31:0] next_rdata;
	logic [1:0] pins;
	assign pins = {i_watchdog_input_b, i_watchdog_input_a};

	// register writes and self test flags
	always_comb
	begin
		next_reg4 = o_reg4_voltage_code;
		next_reg5 = o_reg5_voltage_code;
		next_reg6 = o_reg6_voltage_code;
		next_reg7 = o_reg7_voltage_code;
		next_warn = o_warning_widths;
		next_fault = o_fault_widths;
		next_per = o_peripheral_error_limit;
		next_sys = o_system_error_limit;
		next_trig = trig;
		next_go = 1'b0;
		next_ctrl = ctrl;
		next_long_limit = long_limit;
		next_short_limit = short_limit;
		next_selftest_width = selftest_width;
		if (i_req.wr)
		begin
			// only the documented field bits are stored; the rest is dropped
			case (i_req.addr) // see [RULE21]
				`RMD_LDO4_OFS: next_reg4 = i_req.wdata[2:0]; // see [RULE1]
				`RMD_LDO5_OFS: next_reg5 = i_req.wdata[2:0]; // see [RULE1]
				`RMD_LDO6_OFS: next_reg6 = i_req.wdata[1:0]; // see [RULE2]
				`RMD_LDO7_OFS: next_reg7 = i_req.wdata[1:0]; // see [RULE2]
				`RMD_WARN_OFS: next_warn = i_req.wdata[27:0]; // see [RULE3]
				`RMD_FAULT_OFS: next_fault = i_req.wdata[27:0]; // see [RULE4]
				`RMD_ERR_OFS:
				begin
					next_per = i_req.wdata[`RMD_ERR_PER_LSB +: 3]; // see [RULE5]
					next_sys = i_req.wdata[`RMD_ERR_SYS_LSB +: 3]; // see [RULE6]
				end
				`RMD_TRIG_OFS:
				begin
					next_trig = i_req.wdata[0];
					next_go = i_req.wdata[0]; // see [RULE7]
				end
				`RMD_A_CTRL_OFS: next_ctrl[0] = i_req.wdata[2:0]; // see [RULE11]
				`RMD_A_HI_OFS: next_long_limit[0] = i_req.wdata[WIDTH_BITS-1:0]; // see [RULE14]
				`RMD_A_LO_OFS: next_short_limit[0] = i_req.wdata[WIDTH_BITS-1:0]; // see [RULE15]
				`RMD_A_WID_OFS: next_selftest_width = i_req.wdata[WIDTH_BITS-1:0];
				`RMD_B_CTRL_OFS: next_ctrl[1] = i_req.wdata[2:0]; // see [RULE17] [RULE18]
				`RMD_B_HI_OFS: next_long_limit[1] = i_req.wdata[WIDTH_BITS-1:0]; // see [RULE19]
				`RMD_B_LO_OFS: next_short_limit[1] = i_req.wdata[WIDTH_BITS-1:0];
				default: next_trig = trig;
			endcase
		end
		// a done pulse in the trigger cycle still lands
		next_done = (next_go ? 7'h00 : done) | i_check_done; // see [RULE20] [RULE8]
		next_pass = ((next_go ? 7'h00 : pass) & ~i_check_done)
			| (i_check_pass & i_check_done); // see [RULE9]
		next_busy = next_go | (busy & ~(&next_done));
		// hardware capture beats a host write in the same cycle
		if (busy && pulse_end[0])
			next_selftest_width = width_seen[0]; // see [RULE16]
	end

	always_ff @(posedge i_mclk or posedge i_rst)
	begin
		if (i_rst)
		begin
			o_reg4_voltage_code <= `RMD_LDO_LOW_RST;
			o_reg5_voltage_code <= `RMD_LDO_LOW_RST;
			o_reg6_voltage_code <= `RMD_LDO_HIGH_RST;
			o_reg7_voltage_code <= `RMD_LDO_HIGH_RST;
			o_warning_widths <= `RMD_WARN_RST;
			o_fault_widths <= `RMD_FAULT_RST;
			o_peripheral_error_limit <= `RMD_ERR_LIMIT_RST;
			o_system_error_limit <= `RMD_ERR_LIMIT_RST;
			trig <= 1'b0;
			o_selftest_go <= 1'b0;
			busy <= 1'b0;
			done <= 7'h00;
			pass <= 7'h00;
			ctrl[0] <= `RMD_CTRL_RST;
			ctrl[1] <= `RMD_CTRL_RST;
			long_limit[0] <= `RMD_HI_RST;
			long_limit[1] <= `RMD_HI_RST;
			short_limit[0] <= `RMD_LO_RST;
			short_limit[1] <= `RMD_LO_RST;
			selftest_width <= `RMD_WID_RST;
		end
		else
		begin
			o_reg4_voltage_code <= next_reg4;
			o_reg5_voltage_code <= next_reg5;
			o_reg6_voltage_code <= next_reg6;
			o_reg7_voltage_code <= next_reg7;
			o_warning_widths <= next_warn;
			o_fault_widths <= next_fault;
			o_peripheral_error_limit <= next_per;
			o_system_error_limit <= next_sys;
			trig <= next_trig;
			o_selftest_go <= next_go;
			busy <= next_busy;
			done <= next_done;
			pass <= next_pass;
			ctrl <= next_ctrl;
			long_limit <= next_long_limit;
			short_limit <= next_short_limit;
			selftest_width <= next_selftest_width;
		end
	end

	// read data, one cycle after the request
	always_comb
	begin
		next_rdata = 32'h00000000;
		if (i_req.rd)
		begin
			case (i_req.addr) // see [RULE21]
				`RMD_LDO4_OFS: next_rdata[2:0] = o_reg4_voltage_code;
				`RMD_LDO5_OFS: next_rdata[2:0] = o_reg5_voltage_code;
				`RMD_LDO6_OFS: next_rdata[1:0] = o_reg6_voltage_code;
				`RMD_LDO7_OFS: next_rdata[1:0] = o_reg7_voltage_code;
				`RMD_WARN_OFS: next_rdata[27:0] = o_warning_widths;
				`RMD_FAULT_OFS: next_rdata[27:0] = o_fault_widths;
				`RMD_ERR_OFS: next_rdata[5:0] = {o_peripheral_error_limit, o_system_error_limit};
				`RMD_TRIG_OFS: next_rdata[0] = trig;
				`RMD_STAT_OFS:
				begin
					next_rdata[`RMD_STAT_PASS_LSB +: 7] = pass; // see [RULE9]
					next_rdata[`RMD_STAT_ALL_PASS] = (&pass) & (&done); // see [RULE10]
					next_rdata[`RMD_STAT_DONE_LSB +: 7] = done; // see [RULE8]
					next_rdata[`RMD_STAT_ALL_DONE] = &done; // see [RULE10]
				end
				`RMD_A_CTRL_OFS: next_rdata[2:0] = ctrl[0];
				`RMD_A_HI_OFS: next_rdata[WIDTH_BITS-1:0] = long_limit[0];
				`RMD_A_LO_OFS: next_rdata[WIDTH_BITS-1:0] = short_limit[0];
				`RMD_A_WID_OFS: next_rdata[WIDTH_BITS-1:0] = selftest_width;
				`RMD_B_CTRL_OFS: next_rdata[2:0] = ctrl[1];
				`RMD_B_HI_OFS: next_rdata[WIDTH_BITS-1:0] = long_limit[1];
				`RMD_B_LO_OFS: next_rdata[WIDTH_BITS-1:0] = short_limit[1];
				default: next_rdata = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge i_mclk or posedge i_rst)
	begin
		if (i_rst)
		begin
			o_rdata <= 32'h00000000;
			o_rvalid <= 1'b0;
		end
		else
		begin
			o_rdata <= next_rdata;
			o_rvalid <= i_req.rd;
		end
	end

	// 500 ns time base shared by both width monitors
	always_comb
	begin
		next_tick = (tick_cnt == TICK_LAST);
		next_tick_cnt = next_tick ? 6'h00 : tick_cnt + 6'h01;
	end

	always_ff @(posedge i_mclk or posedge i_rst)
	begin
		if (i_rst)
		begin
			tick_cnt <= 6'h00;
			tick <= 1'b0;
		end
		else
		begin
			tick_cnt <= next_tick_cnt;
			tick <= next_tick;
		end
	end

	generate
		for (genvar c = 0; c < 2; c++)
		begin : g_mon
			logic sync1, sync2, level_prev;
			logic [WIDTH_BITS-1:0] cnt, next_cnt;
			logic next_long, next_short;
			// width is counted in whole 500 ns ticks while the pin is high
			always_comb
			begin
				next_cnt = cnt;
				if (sync2 && !level_prev)
					next_cnt = '0;
				else if (sync2 && tick && cnt != '1) // saturate: a stuck pin never wraps short
					next_cnt = cnt + 1'b1;
				next_long = pulse_end[c] && ctrl[c].check_on && !ctrl[c].long_block
					&& (cnt > long_limit[c]); // see [RULE12] [RULE17]
				next_short = pulse_end[c] && ctrl[c].check_on && !ctrl[c].short_block
					&& (cnt < short_limit[c]); // see [RULE13] [RULE17]
			end

			assign pulse_end[c] = level_prev && !sync2;
			assign width_seen[c] = cnt;

			always_ff @(posedge i_mclk or posedge i_rst)
			begin
				if (i_rst)
				begin
					sync1 <= 1'b0;
					sync2 <= 1'b0;
					level_prev <= 1'b0;
					cnt <= '0;
					o_long_fault[c] <= 1'b0;
					o_short_fault[c] <= 1'b0;
				end
				else
				begin
					sync1 <= pins[c];
					sync2 <= sync1;
					level_prev <= sync2;
					cnt <= next_cnt;
					o_long_fault[c] <= next_long;
					o_short_fault[c] <= next_short;
				end
			end

			sequence s_long_end;
				pulse_end[c] && ctrl[c].check_on && !ctrl[c].long_block
					&& (cnt > long_limit[c]);
			endsequence

			chk_long_fault_raised: assert property (@(posedge i_mclk) disable iff (i_rst) // see [RULE12]
				s_long_end |=> o_long_fault[c] ##1 !o_long_fault[c])
				else $error("long pulse fault missing");
			chk_short_fault_raised: assert property (@(posedge i_mclk) disable iff (i_rst) // see [RULE13]
				(pulse_end[c] && ctrl[c].check_on && !ctrl[c].short_block
					&& (cnt < short_limit[c])) |=> o_short_fault[c])
				else $error("short pulse fault missing");
			chk_masked_quiet: assert property (@(posedge i_mclk) disable iff (i_rst) // see [RULE17]
				(!ctrl[c].check_on || ctrl[c].long_block) |=> !o_long_fault[c])
				else $error("long fault while off or masked");
			chk_disabled_quiet: assert property (@(posedge i_mclk) disable iff (i_rst) // see [RULE11]
				!ctrl[c].check_on |=> !o_short_fault[c])
				else $error("short fault while monitor off");
		end
	endgenerate

	sequence s_trigger_write;
		i_req.wr && i_req.addr == `RMD_TRIG_OFS && i_req.wdata[0];
	endsequence

	chk_trigger_clears: assert property (@(posedge i_mclk) disable iff (i_rst) // see [RULE20]
		(s_trigger_write and (i_check_done == 7'h00)) |=> done == 7'h00 && pass == 7'h00
			&& o_selftest_go)
		else $error("trigger did not clear flags");
	chk_done_sticky: assert property (@(posedge i_mclk) disable iff (i_rst) // see [RULE8]
		(i_check_done != 7'h00) |=> ((done & $past(i_check_done)) == $past(i_check_done)))
		else $error("done flag not set");
	chk_status_read: assert property (@(posedge i_mclk) disable iff (i_rst) // see [RULE10]
		(i_req.rd && i_req.addr == `RMD_STAT_OFS) |=> o_rvalid
			&& o_rdata[0] == &$past(done) && o_rdata[31:16] == 16'h0000)
		else $error("status read wrong");
	chk_reg6_write: assert property (@(posedge i_mclk) disable iff (i_rst) // see [RULE2]
		(i_req.wr && i_req.addr == `RMD_LDO6_OFS) |=> o_reg6_voltage_code == $past(i_req.wdata[1:0]))
		else $error("regulator 6 code not stored");
	chk_tick_spacing: assert property (@(posedge i_mclk) disable iff (i_rst) // see [RULE14]
		tick |=> !tick [*8])
		else $error("time base ticks too close");
	chk_width_capture: assert property (@(posedge i_mclk) disable iff (i_rst) // see [RULE16]
		(busy && pulse_end[0]) |=> selftest_width == $past(width_seen[0]))
		else $error("self test width not recorded");
endmodule // rail_monitor_diag_registers

// *** logic/rail_monitor_pkg.sv ***
package rail_monitor_pkg;
	typedef struct packed {
		logic wr;
		logic rd;
		logic [15:0] addr;
		logic [31:0] wdata;
	} reg_req_t;
	typedef struct packed {
		logic long_block;
		logic short_block;
		logic check_on;
	} pulse_ctrl_t;
endpackage

// *** tb/host_port_model.sv ***
`timescale 1ns/1ns
module host_port_model (
	// clock
	input wire logic i_mclk,
	// answer from the register bank
	input wire logic [31:0] i_rdata,
	input wire logic i_rvalid,
	// decoded request
	output rail_monitor_pkg::reg_req_t o_req
);
	initial o_req = '0;
	// idle bus shows the inverse so a stale address is never mistaken for a live one
	task automatic wr(input logic [15:0] a, input logic [31:0] d);
	begin
		@(negedge i_mclk);
		o_req.addr = a;
		o_req.wdata = d;
		o_req.wr = 1'b1;
		@(negedge i_mclk);
		o_req.wr = 1'b0;
		o_req.addr = ~a;
		o_req.wdata = ~d;
	end
	endtask
	task automatic rd(input logic [15:0] a, output logic [31:0] d, output logic v);
	begin
		@(negedge i_mclk);
		o_req.addr = a;
		o_req.rd = 1'b1;
		@(negedge i_mclk);
		d = i_rdata;
		v = i_rvalid;
		o_req.rd = 1'b0;
		o_req.addr = ~a;
	end
	endtask
endmodule // host_port_model

// *** tb/rail_monitor_diag_registers_bench.sv ***
`timescale 1ns/1ns
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin error_cnt++; $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module rail_monitor_diag_registers_bench;
	logic i_mclk = 1'b0;
	logic i_rst = 1'b1;
	logic [6:0] check_done = 7'h00;
	logic [6:0] check_pass = 7'h00;
	logic [1:0] pin = 2'h0;
	rail_monitor_pkg::reg_req_t req;
	logic [31:0] rdata;
	logic rvalid;
	logic [2:0] c4;
	logic [2:0] c5;
	logic [1:0] c6;
	logic [1:0] c7;
	logic [27:0] warn;
	logic [27:0] fault;
	logic [2:0] per;
	logic [2:0] sys;
	logic go;
	logic [1:0] longf;
	logic [1:0] shortf;
	int error_cnt = 0;
	int n_checks = 0;
	int cycles = 0;
	logic [7:0] long_cnt [2] = '{8'h00, 8'h00};
	logic [7:0] short_cnt [2] = '{8'h00, 8'h00};
	logic [31:0] rst_val [16] = '{32'h1, 32'h1, 32'h1, 32'h1, 32'h5555555, 32'hfaaaaaa,
		32'h3f, 32'h0, 32'h0, 32'h0, 32'h47e, 32'h352, 32'h898, 32'h0, 32'h47e, 32'h352};
	logic [31:0] mask [16] = '{32'h7, 32'h7, 32'h3, 32'h3, 32'hfffffff, 32'hfffffff,
		32'h3f, 32'h1, 32'h0, 32'h7, 32'h3ffff, 32'h3ffff, 32'h3ffff, 32'h7, 32'h3ffff, 32'h3ffff};

	host_port_model i_host (.i_mclk(i_mclk), .i_rdata(rdata), .i_rvalid(rvalid), .o_req(req));
	rail_monitor_diag_registers i_dut (
		.i_mclk(i_mclk), .i_rst(i_rst), .i_req(req), .o_rdata(rdata), .o_rvalid(rvalid),
		.o_reg4_voltage_code(c4), .o_reg5_voltage_code(c5), .o_reg6_voltage_code(c6),
		.o_reg7_voltage_code(c7), .o_warning_widths(warn), .o_fault_widths(fault),
		.o_peripheral_error_limit(per), .o_system_error_limit(sys), .o_selftest_go(go),
		.i_check_done(check_done), .i_check_pass(check_pass), .i_watchdog_input_a(pin[0]),
		.i_watchdog_input_b(pin[1]), .o_long_fault(longf), .o_short_fault(shortf)
	);

	always #5 i_mclk = ~i_mclk;

	// a fault standing longer than one cycle shows up as a count above one
	always @(posedge i_mclk)
	begin
		cycles++;
		for (int i = 0; i < 2; i++)
		begin
			if (longf[i] === 1'b1)
				long_cnt[i]++;
			if (shortf[i] === 1'b1)
				short_cnt[i]++;
		end
		if (cycles == 20000)
		begin
			error_cnt++;
			end_sim();
		end
	end

	task automatic end_sim();
	begin
		if (error_cnt == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	end
	endtask

	function automatic logic [15:0] addr_of(input int i);
		return 16'(32'h8028 + 4 * i);
	endfunction

	task automatic rd_chk(input logic [15:0] a, input logic [31:0] e);
		logic [31:0] d;
		logic v;
	begin
		i_host.rd(a, d, v);
		`CHK("rvalid", 1'b1, v)
		`CHK("rdata", e, d)
	end
	endtask

	task automatic t_reset();
	begin
		for (int i = 0; i < 8; i++)
			rd_chk(addr_of(i), rst_val[i]);
		for (int i = 8; i < 16; i++)
			rd_chk(addr_of(i), rst_val[i]);
		`CHK("reg5", 3'h1, c5)
		`CHK("reg7", 2'h1, c7)
		`CHK("warn", 28'h5555555, warn)
		`CHK("fault", 28'hfaaaaaa, fault)
	end
	endtask

	task automatic t_write();
	begin
		for (int i = 0; i < 16; i++)
			i_host.wr(addr_of(i), 32'haaaaaaaa);
		for (int i = 0; i < 16; i++)
			rd_chk(addr_of(i), 32'haaaaaaaa & mask[i]);
		i_host.wr(16'h8068, 32'hffffffff);
		rd_chk(16'h8068, 32'h0);
		`CHK("reg4", 3'h2, c4)
		`CHK("reg6", 2'h2, c6)
		`CHK("warn", 28'haaaaaaa, warn)
		`CHK("fault", 28'haaaaaaa, fault)
		`CHK("per", 3'h5, per)
		`CHK("sys", 3'h2, sys)
	end
	endtask

	task automatic wd_case(input int i, input int n, input logic [7:0] el, input logic [7:0] es);
	begin
		long_cnt[i] = 8'h00;
		short_cnt[i] = 8'h00;
		@(negedge i_mclk);
		pin[i] = 1'b1;
		repeat (n) @(negedge i_mclk);
		pin[i] = 1'b0;
		repeat (10) @(negedge i_mclk);
		`CHK("long", el, long_cnt[i])
		`CHK("short", es, short_cnt[i])
	end
	endtask

	// limits 6 and 2 ticks; widths of 0.5, 4 and 9 ticks stay clear of the one-tick jitter
	task automatic t_wd(input int i);
		logic [15:0] base;
	begin
		base = i ? 16'h805c : 16'h804c;
		i_host.wr(base + 16'h4, 32'h6);
		i_host.wr(base + 16'h8, 32'h2);
		i_host.wr(base, 32'h1);
		wd_case(i, 25, 8'h0, 8'h1);
		wd_case(i, 200, 8'h0, 8'h0);
		wd_case(i, 450, 8'h1, 8'h0);
		i_host.wr(base, 32'h7);
		wd_case(i, 25, 8'h0, 8'h0);
		wd_case(i, 450, 8'h0, 8'h0);
		i_host.wr(base, 32'h0);
		wd_case(i, 450, 8'h0, 8'h0);
		wd_case(i, 25, 8'h0, 8'h0);
	end
	endtask

	task automatic run_checks(input logic [6:0] pass);
	begin
		for (int k = 6; k >= 0; k--)
		begin
			@(negedge i_mclk);
			check_done = 7'(1 << k);
			check_pass = pass;
			@(negedge i_mclk);
			check_done = 7'h00;
		end
	end
	endtask

	task automatic t_self();
		logic [31:0] d;
		logic v;
	begin
		i_host.wr(16'h804c, 32'h1);
		i_host.wr(16'h8044, 32'h1);
		`CHK("go", 1'b1, go)
		@(negedge i_mclk);
		`CHK("go", 1'b0, go)
		wd_case(0, 200, 8'h0, 8'h0);
		i_host.rd(16'h8058, d, v);
		`CHK("width", 1'b1, (d >= 32'h3 && d <= 32'h5))
		run_checks(7'h5f);
		rd_chk(16'h8048, {16'h0, 7'h5f, 1'b0, 7'h7f, 1'b1});
		i_host.wr(16'h8044, 32'h1);
		rd_chk(16'h8048, 32'h0);
		run_checks(7'h7f);
		rd_chk(16'h8048, 32'hffff);
	end
	endtask

	initial
	begin
		repeat (4) @(negedge i_mclk);
		i_rst = 1'b0;
		t_reset();
		t_write();
		t_wd(0);
		t_wd(1);
		t_self();
		end_sim();
	end
endmodule // rail_monitor_diag_registers_bench
